// ===== fsel_map.svh
/*
  Constants for the four-to-one select multiplexer: widths, reset values
  and the fixed latency figures of the synchronised datapath.
  Assumes inclusion by bare name from every file that needs the values.
*/
`ifndef FSEL_MAP_SVH
`define FSEL_MAP_SVH

// Channel counts the block can be built for
`define FSEL_CH_NARROW     4
`define FSEL_CH_WIDE       8

// Select widths that go with each channel count
`define FSEL_SEL_NARROW    2
`define FSEL_SEL_WIDE      3

// Synchroniser depth on every pin input
`define FSEL_SYNC_STAGES   2

// Reset levels of the output and the input history
`define FSEL_OUT_RST       1'b0
`define FSEL_PIN_RST       1'b0

// Clock period in ns and edges from a stable pin change to the output
`define FSEL_CLK_PERIOD_NS 25
`define FSEL_LATENCY_EDGES 4

`endif

// ===== fsel_pkg.sv
/*
  Types shared by the four-to-one select multiplexer modules.
  Assumes fsel_map.svh is available for the numeric constants.
*/
`default_nettype none

package fsel_pkg;

  // Update sequencer states
  typedef enum logic [0:0] {
    FSEL_ST_IDLE,
    FSEL_ST_EVAL
  } fsel_state_e;

  // Widest select code the block can carry
  typedef logic [2:0] fsel_sel_t;

endpackage : fsel_pkg

`default_nettype wire

// ===== fsel_sync_if.sv
/*
  Carrier between the multiplexer core and its input synchroniser:
  raw pin levels in, clock-aligned levels out.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface fsel_sync_if #(
  parameter int unsigned WIDTH = 6
);

  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] sync;

  // Synchroniser end
  modport syncer (
    input  raw,
    output sync
  );

  // Core end
  modport user (
    output raw,
    input  sync
  );

endinterface : fsel_sync_if

`default_nettype wire

// ===== fsel_sync.sv
/*
  Two-flop synchroniser, one chain per pin.
  Assumes raw levels are asynchronous to clk_sys_i and carry no glitch
  that must be seen; a pulse shorter than a clock may be missed.
*/
`timescale 1ns/100ps
`default_nettype none

`include "fsel_map.svh"

module fsel_sync #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  fsel_sync_if.syncer     sync_if
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stab_q;

  // One chain per bit; the first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_chain
      always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
          meta_q[gi] <= `FSEL_PIN_RST;
          stab_q[gi] <= `FSEL_PIN_RST;
        end else begin
          meta_q[gi] <= sync_if.raw[gi];
          stab_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  assign sync_if.sync = stab_q;

endmodule : fsel_sync

`default_nettype wire

// ===== fsel_mux.sv
/*
  Four-to-one (optionally eight-to-one) select multiplexer with a
  registered output. Channel and select pins are synchronised, any change
  on any of them starts a re-evaluation, and the output follows the
  selected channel four edges later, three for each further change on consecutive cycles.
  Assumes all pins are driven by outside logic asynchronous to clk_sys_i;
  the upper channels and top select bit are ignored in four-channel builds.
*/
`timescale 1ns/100ps
`default_nettype none

`include "fsel_map.svh"

// Functional notes
// RULE1: Selects both low: output follows channel zero.
// RULE2: High select low, low select high: output follows channel one.
// RULE3: High select high, low select low: output follows channel two.
// RULE4: Selects both high: output follows channel three.
// RULE5: Any channel or select change re-evaluates the output.
// RULE6: Four channel inputs, two selects, one output.
// RULE7: Eight-channel build uses three selects, same binary scheme.
// RULE8: Inputs synchronised, output registered, fixed small latency; code takes four edges, three for further changes on consecutive cycles.
module fsel_mux #(
  parameter int unsigned NUM_CH = `FSEL_CH_NARROW
) (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  // Channel and select pins, all asynchronous levels
  input  wire logic       channel_in_zero_i,
  input  wire logic       channel_in_one_i,
  input  wire logic       channel_in_two_i,
  input  wire logic       channel_in_three_i,
  input  wire logic [3:0] channel_in_upper_i,
  input  wire logic       select_low_bit_i,
  input  wire logic       select_high_bit_i,
  input  wire logic       select_top_bit_i,
  // Selected level and status, all straight from flops
  output logic            mux_out_o,
  output logic            mux_upd_o,
  output logic            mux_busy_o,
  output logic [2:0]      mux_sel_o
);

  // Select width follows the channel count
  // Four channels need two select bits, eight need three
  localparam int unsigned SEL_W = (NUM_CH == `FSEL_CH_WIDE) ? `FSEL_SEL_WIDE : `FSEL_SEL_NARROW;
  localparam int unsigned PIN_W = NUM_CH + SEL_W;

  // Only the two documented widths have a selection scheme
  generate
    if (NUM_CH != `FSEL_CH_NARROW && NUM_CH != `FSEL_CH_WIDE) begin : g_bad_width
      $error("fsel_mux: NUM_CH must be 4 or 8");
    end
  endgenerate

  // The fixed latency rests on two sync flops, one sequencer edge
  // and one output edge; a deeper chain would break that figure.
  // Refused here rather than left to a late surprise downstream
  generate
    if (`FSEL_SYNC_STAGES != 2) begin : g_bad_sync
      $error("fsel_mux: the synchroniser is built two flops deep");
    end
    if (`FSEL_LATENCY_EDGES != `FSEL_SYNC_STAGES + 2) begin : g_bad_lat
      $error("fsel_mux: latency figure does not match the datapath");
    end
  endgenerate

  // Gathered pin levels: channels low, selects above
  logic [NUM_CH-1:0]   chan_raw;
  logic [SEL_W-1:0]    sel_raw;
  logic [NUM_CH-1:0]   chan_s;
  logic [SEL_W-1:0]    sel_s;
  logic [PIN_W-1:0]    pins_s;

  // History and sequencer state
  logic [PIN_W-1:0]    prev_q;
  logic                pins_changed;
  fsel_pkg::fsel_state_e state_q;
  fsel_pkg::fsel_state_e state_d;

  // Output stage
  // Status outputs are extras for observing the sequencer
  logic [NUM_CH-1:0]   chan_hit;
  genvar               ci;
  logic                pick;
  logic                out_q;
  logic                out_d;
  logic                upd_q;
  logic                busy_q;
  fsel_pkg::fsel_sel_t sel_q;
  fsel_pkg::fsel_sel_t sel_wide;

  fsel_sync_if #(.WIDTH(PIN_W)) pin_if ();

  // Channel vector and select code, bit 0 is the low select
  generate
    if (NUM_CH == `FSEL_CH_WIDE) begin : g_wide
      assign chan_raw = {channel_in_upper_i, channel_in_three_i, channel_in_two_i,
                         channel_in_one_i, channel_in_zero_i};                 // see RULE7
      assign sel_raw  = {select_top_bit_i, select_high_bit_i, select_low_bit_i}; // see RULE7
    end else begin : g_narrow
      assign chan_raw = {channel_in_three_i, channel_in_two_i,
                         channel_in_one_i, channel_in_zero_i};                 // see RULE6
      assign sel_raw  = {select_high_bit_i, select_low_bit_i};                 // see RULE6
    end
  endgenerate

  // Every pin passes two flops before the core looks at it
  assign pin_if.raw = {sel_raw, chan_raw};                                     // see RULE8

  fsel_sync #(
    .WIDTH(PIN_W)
  ) i_fsel_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .sync_if   (pin_if)
  );

  assign pins_s = pin_if.sync;
  assign chan_s = pins_s[NUM_CH-1:0];
  assign sel_s  = pins_s[PIN_W-1:NUM_CH];

  // Binary select: 00 zero, 01 one, 10 two, 11 three (and on to seven)
  // Per-channel hit keeps the decode flat for the eight-channel build
  generate
    for (ci = 0; ci < NUM_CH; ci++) begin : g_hit
      assign chan_hit[ci] = (sel_s == SEL_W'(ci)) && chan_s[ci];   // see RULE1 see RULE2 see RULE3 see RULE4
    end
  endgenerate

  assign pick  = |chan_hit;
  assign out_d = (state_q == fsel_pkg::FSEL_ST_EVAL) ? pick : out_q;

  // Select code widened for the status output
  assign sel_wide = fsel_pkg::fsel_sel_t'(sel_s);

  // Any difference against last cycle, channel or select, counts
  assign pins_changed = (pins_s != prev_q);                                    // see RULE5

  // Edge walk for one pin change, counted from the edge that samples it:
  //   edge 1  first synchroniser flop takes the new level
  //   edge 2  second flop holds it; the history compare sees a difference
  //   edge 3  sequencer enters evaluation, busy rises with it
  //   edge 4  output and update pulse register the selected level
  // Changes on consecutive cycles keep the sequencer evaluating, so the
  // output registers each further sampled value one edge sooner, at edge 3.

  // A change seen during evaluation queues another pass, so none is lost
  always_comb begin
    state_d = state_q;
    case (state_q)
      fsel_pkg::FSEL_ST_IDLE: begin
        if (pins_changed) begin
          state_d = fsel_pkg::FSEL_ST_EVAL;                                    // see RULE5
        end
      end
      fsel_pkg::FSEL_ST_EVAL: begin
        if (pins_changed) begin
          state_d = fsel_pkg::FSEL_ST_EVAL;
        end else begin
          state_d = fsel_pkg::FSEL_ST_IDLE;
        end
      end
      default: begin
        state_d = fsel_pkg::FSEL_ST_IDLE;
      end
    endcase
  end

  // Input history, reset to the synchroniser reset level
  // Non-zero pins at release differ from it, so a first pass runs
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      prev_q <= {PIN_W{`FSEL_PIN_RST}};
    end else begin
      prev_q <= pins_s;
    end
  end

  // Sequencer
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_q <= fsel_pkg::FSEL_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Registered output; holds between evaluations like a latched pin
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      out_q <= `FSEL_OUT_RST;
    end else begin
      out_q <= out_d;                                                          // see RULE8
    end
  end

  // Status: update pulse, busy level and the select in force
  // Busy follows the next state, so it leads the update pulse by one edge
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      upd_q  <= 1'b0;
      busy_q <= 1'b0;
      sel_q  <= 3'h0;
    end else begin
      upd_q  <= (state_q == fsel_pkg::FSEL_ST_EVAL);
      busy_q <= (state_d == fsel_pkg::FSEL_ST_EVAL);
      sel_q  <= sel_wide;
    end
  end

  assign mux_out_o  = out_q;
  assign mux_upd_o  = upd_q;
  assign mux_busy_o = busy_q;
  assign mux_sel_o  = sel_q;

endmodule : fsel_mux

`default_nettype wire

// ===== fsel_chk_asserts.sv
/* Port checker for fsel_mux, bound after the module.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module fsel_chk #(parameter int unsigned NUM_CH = 4) (
  input wire logic       clk_sys_i,
  input wire logic       sys_rst_i,
  input wire logic       channel_in_zero_i,
  input wire logic       channel_in_one_i,
  input wire logic       channel_in_two_i,
  input wire logic       channel_in_three_i,
  input wire logic [3:0] channel_in_upper_i,
  input wire logic       select_low_bit_i,
  input wire logic       select_high_bit_i,
  input wire logic       select_top_bit_i,
  input wire logic       mux_out_o,
  input wire logic       mux_upd_o,
  input wire logic       mux_busy_o,
  input wire logic [2:0] mux_sel_o
);
  // Live pins; upper ones count only in wide builds
  wire logic [2:0] sc = {NUM_CH == 8 && select_top_bit_i, select_high_bit_i, select_low_bit_i};
  wire logic [7:0] ch = {NUM_CH == 8 ? channel_in_upper_i : 4'h0, channel_in_three_i, channel_in_two_i,
    channel_in_one_i, channel_in_zero_i};
  logic      [2:0] cnt_q;
  // Edges since reset; history from before it is not trusted
  always_ff @(posedge clk_sys_i) cnt_q <= sys_rst_i ? 3'h0 : cnt_q + 3'(cnt_q != 3'h7);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sel_zero_a: assert property (cnt_q > 4 && $past(sc, 4) == 0 |-> mux_out_o == $past(ch[0], 4))
    else $error("not ch0");
  sel_one_a: assert property (cnt_q > 4 && $past(sc, 4) == 1 |-> mux_out_o == $past(ch[1], 4))
    else $error("not ch1");
  sel_two_a: assert property (cnt_q > 4 && $past(sc, 4) == 2 |-> mux_out_o == $past(ch[2], 4))
    else $error("not ch2");
  sel_three_a: assert property (cnt_q > 4 && $past(sc, 4) == 3 |-> mux_out_o == $past(ch[3], 4))
    else $error("not ch3");
  any_change_a: assert property (cnt_q > 1 && {sc, ch} != $past({sc, ch}) |-> ##4 mux_upd_o)
    else $error("no update");
  out_cause_a: assert property ($changed(mux_out_o) |-> mux_upd_o)
    else $error("stray change");
  upd_busy_a: assert property (mux_upd_o |-> $past(mux_busy_o))
    else $error("update without busy");
  sel_code_a: assert property (cnt_q > 3 |-> mux_sel_o == $past(sc, 3))
    else $error("bad select code");
  c_high: cover property (mux_upd_o && mux_out_o);
  c_low: cover property (mux_upd_o && !mux_out_o);
  c_sel3: cover property (mux_sel_o == 3'h3);
endmodule : fsel_chk
bind fsel_mux fsel_chk #(.NUM_CH(NUM_CH)) i_fsel_chk (.clk_sys_i, .sys_rst_i, .channel_in_zero_i,
  .channel_in_one_i, .channel_in_two_i, .channel_in_three_i, .channel_in_upper_i, .select_low_bit_i,
  .select_high_bit_i, .select_top_bit_i, .mux_out_o, .mux_upd_o, .mux_busy_o, .mux_sel_o);
`default_nettype wire

// ===== fsel_pins.sv
/* Outside logic driving the channel and select pins.
   Assumes bench commands; bits 3:0 ch0-3, 7:4 upper, 10:8 select. */
`timescale 1ns/100ps
`default_nettype none
module fsel_pins (
  input  wire logic        clk_sys_i,
  input  wire logic [10:0] cmd_i,
  output logic      [10:0] pin_o
);
  // Pins move just after an edge and hold a full cycle, never mid-cycle
  initial pin_o = 11'h0;
  always @(posedge clk_sys_i) pin_o <= cmd_i;
endmodule : fsel_pins
`default_nettype wire

// ===== four_to_one_select_mux_tb_top.sv
/* Self-checking bench for fsel_mux, four- and eight-channel builds.
   Assumes fsel_pins as pin driver and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module four_to_one_select_mux_tb_top;
  logic        clk_sys_i   = 1'b0;
  logic        sys_rst_i   = 1'b1;
  logic [10:0] cmd         = 11'h0;
  wire  [10:0] pin;
  wire  [2:0]  sel;
  wire         out;
  wire         upd;
  wire         busy;
  wire  [2:0]  sel_w;
  wire         out_w;
  wire         upd_w;
  wire         busy_w;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  // 40 MHz system clock
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  fsel_pins i_fsel_pins (.clk_sys_i(clk_sys_i), .cmd_i(cmd), .pin_o(pin));
  fsel_mux #(.NUM_CH(4)) i_fsel_mux (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .channel_in_zero_i(pin[0]), .channel_in_one_i(pin[1]),
    .channel_in_two_i(pin[2]), .channel_in_three_i(pin[3]),
    .channel_in_upper_i(pin[7:4]), .select_low_bit_i(pin[8]),
    .select_high_bit_i(pin[9]), .select_top_bit_i(pin[10]),
    .mux_out_o(out), .mux_upd_o(upd), .mux_busy_o(busy), .mux_sel_o(sel));
  // Eight-channel build on the same pins
  fsel_mux #(.NUM_CH(8)) i_fsel_mux_wide (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .channel_in_zero_i(pin[0]), .channel_in_one_i(pin[1]),
    .channel_in_two_i(pin[2]), .channel_in_three_i(pin[3]),
    .channel_in_upper_i(pin[7:4]), .select_low_bit_i(pin[8]),
    .select_high_bit_i(pin[9]), .select_top_bit_i(pin[10]),
    .mux_out_o(out_w), .mux_upd_o(upd_w), .mux_busy_o(busy_w), .mux_sel_o(sel_w));
  // Hang guard; the tests need under 250 cycles
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      miscompares++;
      print_verdict;
    end
  end
  task automatic ck(input logic [2:0] seen, input logic [2:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : ck
  // Pins change at an edge; checks land 1 ns past an edge
  task automatic put(input logic [10:0] v);
    @(posedge clk_sys_i) cmd <= v;
  endtask : put
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  // Each code with its channel high, then low with all other channel pins and the top select high
  task automatic t_sel;
    for (int c = 0; c < 4; c++) begin
      put({1'b0, 2'(c), 4'h0, 4'h1 << c});
      tick(6);
      ck(out, 1'b1);
      put({1'b1, 2'(c), 4'hf, 4'hf ^ (4'h1 << c)});
      tick(6);
      ck(out, 1'b0);
    end
    $display("t_sel done");
  endtask : t_sel
  // Select change: exact edge of the output and status
  task automatic t_lat;
    put({3'h0, 4'h0, 4'h8});
    tick(6);
    ck(out, 1'b0);
    put({3'h7, 4'h0, 4'h8});
    tick(4);
    ck(out, 1'b0);
    ck(sel, 3'h3);
    ck(busy, 1'b1);
    tick(1);
    ck(out, 1'b1);
    ck(upd, 1'b1);
    ck(busy, 1'b0);
    tick(1);
    ck(upd, 1'b0);
    $display("t_lat done");
  endtask : t_lat
  // Unselected channel change still re-evaluates once
  task automatic t_any;
    int n;
    n = 0;
    put({3'h7, 4'h0, 4'h9});
    repeat (7) begin
      tick(1);
      if (upd === 1'b1) n++;
    end
    ck(3'(n), 3'h1);
    ck(out, 1'b1);
    $display("t_any done");
  endtask : t_any
  // Mid-run reset with pins non-zero: outputs clear, then re-evaluate
  task automatic t_rst;
    put({3'h7, 4'h0, 4'h8});
    tick(6);
    @(posedge clk_sys_i) sys_rst_i <= 1'b1;
    tick(3);
    ck(out, 1'b0);
    ck(upd, 1'b0);
    ck(sel, 3'h0);
    @(posedge clk_sys_i) sys_rst_i <= 1'b0;
    tick(1);
    ck(out, 1'b0);
    tick(4);
    ck(out, 1'b1);
    $display("t_rst done");
  endtask : t_rst
  // Eight-channel build: each three-bit code, channel high then low
  task automatic t_wide;
    for (int c = 0; c < 8; c++) begin
      put({3'(c), 8'h1 << c});
      tick(6);
      ck(out_w, 1'b1);
      ck(sel_w, 3'(c));
      put({3'(c), 8'hff ^ (8'h1 << c)});
      tick(6);
      ck(out_w, 1'b0);
    end
    $display("t_wide done");
  endtask : t_wide
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_sel;
    t_lat;
    t_any;
    t_rst;
    t_wide;
    print_verdict;
  end
endmodule : four_to_one_select_mux_tb_top
`default_nettype wire
